// ### design/ssp_pkg.sv
package ssp_pkg;

  // ----------------------------------------------------------------
  // Set encoding constants
  // ----------------------------------------------------------------
  localparam logic [31:0] SET_MAX_BITS  = 32'h0000_0100; // Largest count
  localparam logic [9:0]  SET_ROUND     = 10'h01f;       // Round up words
  localparam int unsigned SET_SHIFT     = 5;             // Log2 of bits per word
  localparam logic [14:0] SEQ_HDR_LAST  = 15'h0002;      // Count word idx
  localparam logic [14:0] FRAG_HDR_LAST = 15'h0001;      // Count word idx
  localparam logic [2:0]  SEQ_BM_FIRST  = 3'h3;          // First map word
  localparam logic [2:0]  FRAG_BM_FIRST = 3'h2;          // First map word
  localparam logic [14:0] LOC_LAST      = 15'h0001;      // Address, port

  // ----------------------------------------------------------------
  // Parameter list codes
  // ----------------------------------------------------------------
  localparam logic [15:0] PADDING_RECORD_CODE = 16'h0000;
  localparam logic [15:0] LIST_END_CODE       = 16'h0001;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W     = 32;   // Stream word width
  localparam int unsigned FIFO_DEPTH = 16;   // Output buffer words
  localparam logic [14:0] CNT_RST    = 15'h0000;
  localparam logic [13:0] VAL_RST    = 14'h0000;
  localparam logic [1:0]  POS_RST    = 2'h0;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;

  // Command kinds
  typedef enum logic [3:0] {
    SSP_SEQSET  = 4'h0, // Sequence-number set
    SSP_FRAGSET = 4'h1, // Fragment-number set
    SSP_PARAM   = 4'h2, // Record header
    SSP_SENT    = 4'h3, // List end record
    SSP_PAD     = 4'h4, // Padding record with zero body
    SSP_DATA    = 4'h5, // One raw record value word
    SSP_LOC     = 4'h6, // Compact IPv4 endpoint
    SSP_PLD     = 4'h7, // One aligned payload field
    SSP_PLEND   = 4'h8  // Close payload, flush partial word
  } ssp_kind_t;

  // Encoder states
  typedef enum logic [1:0] {
    SSP_IDLE = 2'h0,
    SSP_EMIT = 2'h1
  } ssp_state_t;

  // One order from the message builder
  typedef struct packed {
    ssp_kind_t         kind;
    logic              byte_order_flag;  // 1: little-endian
    logic [63:0]       set_start_number; // Locator: address, port
    logic [31:0]       set_bit_count;
    logic [7:0][31:0]  bitmap;           // Word 0 holds offset 0
    logic [15:0]       record_kind_code;
    logic [15:0]       rec_len;          // Value bytes
    logic [31:0]       value;            // Data word or payload field
    logic [1:0]        field_size;       // 0:1, 1:2, 2:4 bytes
  } ssp_cmd_t;

  // Byte swap of a 32-bit field
  function automatic logic [31:0] swap32(input logic [31:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Byte swap of two 16-bit fields
  function automatic logic [31:0] swap16x2(input logic [31:0] w);
    swap16x2 = {w[23:16], w[31:24], w[7:0], w[15:8]};
  endfunction

endpackage

// ### design/ssp_host_encoder.sv
`timescale 1ns/1ps
// Functional notes
// - Set covers at most 256 numbers
// - Bitmap bit one means number is member
// - Base at least one, count 1 to 256
// - Map words equal count plus 31 over 32
// - Base, then count, then map words
// - Fragment sets share the set layout
// - Each record starts on four-byte boundary
// - List ends with id one record
// - Id zero pads, body skipped
// - Record value starts without padding
// - Payload fields aligned to own size
// - Compact endpoint is address plus port
// - Byte order flag selects endianness

// ------------------------------------------------------------------
// Output word buffer
// ------------------------------------------------------------------
module ssp_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned D = 16
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem [D];      // Storage
  logic [AW:0]  wr_ptr_ff;    // Write pointer with lap bit
  logic [AW:0]  rd_ptr_ff;    // Read pointer with lap bit
  wire          full;         // All entries used
  wire          empty;        // No entry used
  wire          do_wr;        // Write this cycle
  wire          do_rd;        // Read this cycle

  assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                     (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty     = wr_ptr_ff == rd_ptr_ff;
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign do_wr     = in_valid & ~full;
  assign do_rd     = out_ready & ~empty;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  // Storage write
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // Pointer advance
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(do_wr);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(do_rd);
    end
  end
endmodule

// ------------------------------------------------------------------
// Host-side element encoder
// ------------------------------------------------------------------
module ssp_host_encoder (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire ssp_pkg::ssp_cmd_t cmd,
  output logic                   cmd_error,
  output logic                   list_open,
  output logic [31:0]            tx_word,
  output logic                   tx_valid,
  input  wire logic              tx_ready
);
  ssp_pkg::ssp_state_t state_ff;      // Encoder state
  ssp_pkg::ssp_state_t nxt_state;     // Next state
  ssp_pkg::ssp_cmd_t   cmd_ff;        // Order being emitted
  logic [14:0]         cnt_ff;        // Word index in element
  logic [14:0]         last_ff;       // Index of final word
  logic [13:0]         val_left_ff;   // Value words still owed
  logic                list_open_ff;  // Parameter list is open
  logic                cmd_ready_ff;  // Ready for an order
  logic                cmd_error_ff;  // Order refused pulse
  logic [1:0]          pos_ff;        // Payload byte position
  logic [31:0]         part_ff;       // Partial payload word
  logic [31:0]         tx_word_ff;    // Output word
  logic                tx_valid_ff;   // Output word valid
  logic                cmd_bad;       // Order breaks a limit
  logic [14:0]         nxt_last;      // Final index of new order
  logic [31:0]         reg_word;      // Word for fixed elements

  wire        accept;      // Order taken this cycle
  wire        emitting;    // In emit state
  wire        fifo_rdy;    // Buffer has room
  wire        fifo_ov;     // Buffer has a word
  wire        fifo_or;     // Output stage takes a word
  wire [31:0] fifo_od;     // Buffer head word
  wire        is_pl;       // Payload field order
  wire        is_ple;      // Payload close order
  wire        emit_want;   // This step writes a word
  wire        push;        // Word enters buffer
  wire        step_done;   // Element finished
  wire        lend;        // Little-endian order
  wire [31:0] push_word;   // Word written to buffer
  wire        cnt_ok;      // Bit count in range
  wire [3:0]  map_words;   // Bitmap words of new order
  wire [2:0]  bm_idx;      // Bitmap word being sent
  wire [2:0]  pl_size;     // Field size in bytes
  wire [2:0]  pl_mask;     // Size minus one
  wire [2:0]  pl_algn;     // Aligned field position
  wire        pl_wrap;     // Field needs a fresh word
  wire [2:0]  pl_end;      // Position after the field
  wire        pl_full;     // Field completes the word
  wire [31:0] pl_place;    // Field bytes in their lanes
  wire        fifo_in_ready; // Buffer input side has room

  // ----------------------------------------------------------------
  // Order checks
  // ----------------------------------------------------------------
  assign accept   = (state_ff == ssp_pkg::SSP_IDLE) && cmd_valid &&
                    cmd_ready_ff;
  assign emitting = state_ff == ssp_pkg::SSP_EMIT;
  assign lend     = cmd_ff.byte_order_flag;
  assign cnt_ok   = (cmd.set_bit_count != 32'h0) &&
                    (cmd.set_bit_count <= ssp_pkg::SET_MAX_BITS);
  assign map_words = 4'(({1'b0, cmd.set_bit_count[8:0]} +
                         ssp_pkg::SET_ROUND) >>
                        ssp_pkg::SET_SHIFT);

  // Limit checks and final word index of a new order
  always_comb begin
    cmd_bad  = 1'b0;
    nxt_last = ssp_pkg::CNT_RST;
    case (cmd.kind)
      ssp_pkg::SSP_SEQSET: begin
        cmd_bad  = cmd.set_start_number[63] ||
                   (cmd.set_start_number == 64'h0) || ~cnt_ok;
        nxt_last = ssp_pkg::SEQ_HDR_LAST + 15'(map_words);
      end
      ssp_pkg::SSP_FRAGSET: begin
        cmd_bad  = (cmd.set_start_number[31:0] == 32'h0) ||
                   ~cnt_ok;
        nxt_last = ssp_pkg::FRAG_HDR_LAST + 15'(map_words);
      end
      ssp_pkg::SSP_PARAM: begin
        cmd_bad = (cmd.rec_len[1:0] != 2'h0) || (val_left_ff != 0) ||
                  (cmd.record_kind_code == ssp_pkg::LIST_END_CODE) ||
                  (cmd.record_kind_code ==
                   ssp_pkg::PADDING_RECORD_CODE);
      end
      ssp_pkg::SSP_PAD: begin
        cmd_bad  = (cmd.rec_len[1:0] != 2'h0) ||
                   (val_left_ff != 0);
        nxt_last = {1'b0, cmd.rec_len[15:2]};
      end
      ssp_pkg::SSP_SENT: begin
        cmd_bad = (val_left_ff != 0) || ~list_open_ff;
      end
      ssp_pkg::SSP_DATA: begin
        cmd_bad = val_left_ff == 0;
      end
      ssp_pkg::SSP_LOC: begin
        nxt_last = ssp_pkg::LOC_LAST;
      end
      ssp_pkg::SSP_PLD: begin
        cmd_bad = cmd.field_size == 2'h3;
      end
      ssp_pkg::SSP_PLEND: begin
        cmd_bad = 1'b0;
      end
      default: begin
        cmd_bad = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Fixed element words
  // ----------------------------------------------------------------
  assign bm_idx = (cmd_ff.kind == ssp_pkg::SSP_SEQSET) ?
                  cnt_ff[2:0] - ssp_pkg::SEQ_BM_FIRST :
                  cnt_ff[2:0] - ssp_pkg::FRAG_BM_FIRST;

  // Word at the current index, big-endian before any byte swap
  always_comb begin
    reg_word = ssp_pkg::WORD_RST;
    case (cmd_ff.kind)
      ssp_pkg::SSP_SEQSET: begin
        if (cnt_ff == 15'h0) begin
          reg_word = cmd_ff.set_start_number[63:32];
        end else if (cnt_ff == 15'h1) begin
          reg_word = cmd_ff.set_start_number[31:0];
        end else if (cnt_ff == ssp_pkg::SEQ_HDR_LAST) begin
          reg_word = cmd_ff.set_bit_count;
        end else begin
          reg_word = cmd_ff.bitmap[bm_idx];
        end
      end
      ssp_pkg::SSP_FRAGSET: begin
        if (cnt_ff == 15'h0) begin
          reg_word = cmd_ff.set_start_number[31:0];
        end else if (cnt_ff == ssp_pkg::FRAG_HDR_LAST) begin
          reg_word = cmd_ff.set_bit_count;
        end else begin
          reg_word = cmd_ff.bitmap[bm_idx];
        end
      end
      ssp_pkg::SSP_LOC: begin
        reg_word = (cnt_ff == 15'h0) ? cmd_ff.set_start_number[63:32] :
                                       cmd_ff.set_start_number[31:0];
      end
      default: begin
        reg_word = ssp_pkg::WORD_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Payload field placement
  // ----------------------------------------------------------------
  assign pl_size = 3'h1 << cmd_ff.field_size;
  assign pl_mask = pl_size - 3'h1;
  assign pl_algn = ({1'b0, pos_ff} + pl_mask) & ~pl_mask;
  assign pl_wrap = pl_algn[2];
  assign pl_end  = pl_algn + pl_size;
  assign pl_full = pl_end == 3'h4;

  // One byte lane per loop pass; lane 0 is the first wire byte
  for (genvar j = 0; j < 4; j++) begin : g_lane
    wire [2:0] k  = 3'(j) - pl_algn;
    wire       in = (3'(j) >= pl_algn) && (3'(j) < pl_end);
    wire [2:0] sh = lend ? k : pl_mask - k;
    assign pl_place[31-8*j -: 8] =
      in ? 8'(cmd_ff.value >> {sh, 3'h0}) : 8'h00;
  end

  // ----------------------------------------------------------------
  // Buffer write selection
  // ----------------------------------------------------------------
  assign fifo_rdy  = fifo_in_ready;
  assign is_pl     = cmd_ff.kind == ssp_pkg::SSP_PLD;
  assign is_ple    = cmd_ff.kind == ssp_pkg::SSP_PLEND;
  assign emit_want = is_pl ? (pl_wrap | pl_full) :
                     is_ple ? (pos_ff != 2'h0) : 1'b1;
  assign push      = emitting && fifo_rdy && emit_want;
  assign step_done = emitting && fifo_rdy &&
                     ((is_pl | is_ple) ? ~(is_pl & pl_wrap) :
                                         (cnt_ff == last_ff));
  assign push_word =
    is_pl ? (pl_wrap ? part_ff : (part_ff | pl_place)) :
    is_ple ? part_ff :
    (cmd_ff.kind == ssp_pkg::SSP_PARAM) ?
      (lend ? ssp_pkg::swap16x2({cmd_ff.record_kind_code,
                                 cmd_ff.rec_len}) :
              {cmd_ff.record_kind_code, cmd_ff.rec_len}) :
    (cmd_ff.kind == ssp_pkg::SSP_SENT) ?
      (lend ? ssp_pkg::swap16x2({ssp_pkg::LIST_END_CODE, 16'h0}) :
              {ssp_pkg::LIST_END_CODE, 16'h0}) :
    (cmd_ff.kind == ssp_pkg::SSP_PAD) ?
      ((cnt_ff != 15'h0) ? ssp_pkg::WORD_RST :
       lend ? ssp_pkg::swap16x2({ssp_pkg::PADDING_RECORD_CODE,
                                 cmd_ff.rec_len}) :
              {ssp_pkg::PADDING_RECORD_CODE, cmd_ff.rec_len}) :
    (cmd_ff.kind == ssp_pkg::SSP_DATA) ? cmd_ff.value :
    (lend ? ssp_pkg::swap32(reg_word) : reg_word);

  assign nxt_state = (accept && !cmd_bad) ? ssp_pkg::SSP_EMIT :
                     step_done ? ssp_pkg::SSP_IDLE : state_ff;

  // State, order latch and ready
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= ssp_pkg::SSP_IDLE;
      cmd_ff       <= '0;
      last_ff      <= ssp_pkg::CNT_RST;
      cmd_ready_ff <= 1'b0;
      cmd_error_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cmd_ready_ff <= nxt_state == ssp_pkg::SSP_IDLE;
      cmd_error_ff <= accept && cmd_bad;
      if (accept) begin
        cmd_ff  <= cmd;
        last_ff <= nxt_last;
      end
    end
  end

  // Word index within the element
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= ssp_pkg::CNT_RST;
    end else if (accept) begin
      cnt_ff <= ssp_pkg::CNT_RST;
    end else if (emitting && fifo_rdy && !(is_pl | is_ple)) begin
      cnt_ff <= cnt_ff + 15'h1;
    end
  end

  // Record bookkeeping; repeated ids open new records freely
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      val_left_ff  <= ssp_pkg::VAL_RST;
      list_open_ff <= 1'b0;
    end else if (accept && !cmd_bad) begin
      if (cmd.kind == ssp_pkg::SSP_PARAM) begin
        val_left_ff  <= cmd.rec_len[15:2];
        list_open_ff <= 1'b1;
      end else if (cmd.kind == ssp_pkg::SSP_PAD) begin
        list_open_ff <= 1'b1;
      end else if (cmd.kind == ssp_pkg::SSP_SENT) begin
        list_open_ff <= 1'b0;
      end
    end else if (push && cmd_ff.kind == ssp_pkg::SSP_DATA) begin
      val_left_ff <= val_left_ff - 14'h1;
    end
  end

  // Payload partial word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_ff  <= ssp_pkg::POS_RST;
      part_ff <= ssp_pkg::WORD_RST;
    end else if (emitting && fifo_rdy && (is_ple || (is_pl &&
                 (pl_wrap || pl_full)))) begin
      pos_ff  <= ssp_pkg::POS_RST;
      part_ff <= ssp_pkg::WORD_RST;
    end else if (emitting && fifo_rdy && is_pl) begin
      pos_ff  <= pl_end[1:0];
      part_ff <= part_ff | pl_place;
    end
  end

  // ----------------------------------------------------------------
  // Buffer and output stage
  // ----------------------------------------------------------------
  ssp_fifo #(
    .W (ssp_pkg::WORD_W),
    .D (ssp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_ov),
    .out_ready (fifo_or),
    .out_data  (fifo_od)
  );

  assign fifo_or = ~tx_valid_ff | tx_ready;

  // Registered output word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid_ff <= 1'b0;
      tx_word_ff  <= ssp_pkg::WORD_RST;
    end else if (fifo_or) begin
      tx_valid_ff <= fifo_ov;
      if (fifo_ov) begin
        tx_word_ff <= fifo_od;
      end
    end
  end

  assign cmd_ready = cmd_ready_ff;
  assign cmd_error = cmd_error_ff;
  assign list_open = list_open_ff;
  assign tx_word   = tx_word_ff;
  assign tx_valid  = tx_valid_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_bad_count;
    accept && cmd.kind == ssp_pkg::SSP_SEQSET &&
    cmd.set_bit_count > ssp_pkg::SET_MAX_BITS |=> cmd_error_ff;
  endproperty
  a_bad_count: assert property (p_bad_count)
    else $error("oversize set accepted");

  property p_base_min;
    accept && cmd.kind == ssp_pkg::SSP_FRAGSET &&
    cmd.set_start_number[31:0] == 32'h0 |=>
      cmd_error_ff && state_ff == ssp_pkg::SSP_IDLE;
  endproperty
  a_base_min: assert property (p_base_min)
    else $error("zero base set accepted");

  property p_map_words;
    emitting && cmd_ff.kind == ssp_pkg::SSP_SEQSET |->
      last_ff - ssp_pkg::SEQ_HDR_LAST ==
      15'(({1'b0, cmd_ff.set_bit_count[8:0]} + 10'h1f) >> 5);
  endproperty
  a_map_words: assert property (p_map_words)
    else $error("bitmap word count wrong");

  property p_count_word;
    push && cmd_ff.kind == ssp_pkg::SSP_SEQSET && cnt_ff == 15'h2 &&
    !lend |-> push_word == cmd_ff.set_bit_count;
  endproperty
  a_count_word: assert property (p_count_word)
    else $error("count not third word");

  property p_frag_map;
    push && cmd_ff.kind == ssp_pkg::SSP_FRAGSET && cnt_ff == 15'h2 &&
    !lend |-> push_word == cmd_ff.bitmap[0];
  endproperty
  a_frag_map: assert property (p_frag_map)
    else $error("fragment map misplaced");

  property p_rec_open;
    accept && cmd.kind == ssp_pkg::SSP_PARAM && val_left_ff != 0
    |=> cmd_error_ff;
  endproperty
  a_rec_open: assert property (p_rec_open)
    else $error("record started mid value");

  property p_len_four;
    accept && cmd.kind == ssp_pkg::SSP_PARAM && cmd.rec_len[1:0] != 0
    |=> cmd_error_ff && state_ff == ssp_pkg::SSP_IDLE;
  endproperty
  a_len_four: assert property (p_len_four)
    else $error("unaligned length accepted");

  property p_end_close;
    accept && cmd.kind == ssp_pkg::SSP_SENT && !cmd_bad
    |=> !list_open_ff;
  endproperty
  a_end_close: assert property (p_end_close)
    else $error("list still open after end");

  property p_pad_zero;
    push && cmd_ff.kind == ssp_pkg::SSP_PAD && cnt_ff != 15'h0
    |-> push_word == 32'h0;
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("pad body not zero");

  property p_pl_align;
    emitting && is_pl && !pl_wrap |->
      (pl_algn & pl_mask) == 3'h0 && pl_end <= 3'h4;
  endproperty
  a_pl_align: assert property (p_pl_align)
    else $error("payload field misaligned");

  property p_loc_port;
    push && cmd_ff.kind == ssp_pkg::SSP_LOC && cnt_ff == 15'h1 && lend
    |-> push_word == ssp_pkg::swap32(cmd_ff.set_start_number[31:0]);
  endproperty
  a_loc_port: assert property (p_loc_port)
    else $error("endpoint port wrong");
endmodule

// ### test/ssp_sink_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Stream sink standing for the remote participant
// ----------------------------------------------------------------
module ssp_sink_model (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [31:0] tx_word,
  input  wire logic        tx_valid,
  input  wire logic        stall,
  output logic             tx_ready
);
  logic [31:0] got[$]; // Words taken, in wire order
  // Ready drops while the far side stalls
  assign tx_ready = !stall;
  // Take one word on each accepted edge
  always @(posedge core_clk) begin
    if (arst_n && tx_valid && tx_ready) begin
      got.push_back(tx_word);
    end
  end
endmodule

// ### test/tb_seqset_paramlist_codec.sv
`timescale 1ns/1ps
module tb_seqset_paramlist_codec;
  logic              core_clk;
  logic              arst_n;
  logic              cmd_valid;
  logic              cmd_ready;
  ssp_pkg::ssp_cmd_t cmd;
  ssp_pkg::ssp_cmd_t c;
  logic              cmd_error;
  logic              list_open;
  logic [31:0]       tx_word;
  logic              tx_valid;
  logic              tx_ready;
  logic              stall;
  int                n_fail;
  int                checks_done;
  int                cyc;
  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  ssp_host_encoder ssp_host_encoder_inst (
    .core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .cmd_error(cmd_error),
    .list_open(list_open), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  ssp_sink_model ssp_sink_model_inst (
    .core_clk(core_clk), .arst_n(arst_n), .tx_word(tx_word),
    .tx_valid(tx_valid), .stall(stall), .tx_ready(tx_ready));
  // Clock and hang limit
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic ssp_pkg::ssp_cmd_t mk(ssp_pkg::ssp_kind_t k,
    logic [63:0] b, logic [31:0] n, logic [15:0] id, logic [15:0] ln);
    mk = '0;
    mk.kind = k;
    mk.set_start_number = b;
    mk.set_bit_count = n;
    mk.record_kind_code = id;
    mk.rec_len = ln;
  endfunction
  // Offer one order, hold it to the taking edge, judge the refusal
  task automatic send(ssp_pkg::ssp_cmd_t o, logic err);
    int k;
    k = 0;
    // Let an edge pass so valid never drops and rises in one step
    do begin
      @(posedge core_clk); #1; k++;
    end while (cmd_ready !== 1'b1 && k < 400);
    cmd = o;
    cmd_valid = 1'b1;
    @(posedge core_clk); #1;
    cmd_valid = 1'b0;
    check("cmd_error", {31'h0, cmd_error}, {31'h0, err});
    check("cmd_ready", {31'h0, cmd_ready}, {31'h0, err});
  endtask
  // Wait for one word on the stream and compare it
  task automatic take(logic [31:0] exp);
    int k;
    k = 0;
    while (ssp_sink_model_inst.got.size() == 0 && k < 400) begin
      @(posedge core_clk); #1; k++;
    end
    check("tx_word", ssp_sink_model_inst.got.pop_front(), exp);
  endtask
  // Let the stream settle, then count what is left
  task automatic left(int n);
    repeat (40) @(posedge core_clk);
    #1;
    check("word_count", ssp_sink_model_inst.got.size(), n);
    ssp_sink_model_inst.got.delete();
  endtask
  task automatic wrap_up();
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Sequence set of 33 numbers under far-side stall
  task automatic test_seqset();
    c = mk(ssp_pkg::SSP_SEQSET, 64'h0000_0001_0000_04d2, 32'h21, 0, 0);
    c.bitmap[0] = 32'h3000_0000;
    c.bitmap[1] = 32'h8000_0000;
    send(c, 1'b0);
    repeat (10) @(posedge core_clk);
    #1 stall = 1'b0;
    take(32'h0000_0001); take(32'h0000_04d2);
    take(32'h0000_0021); take(32'h3000_0000); take(32'h8000_0000);
    left(0);
    $display("test seqset done");
  endtask
  // Fragment set, little-endian
  task automatic test_fragset();
    c = mk(ssp_pkg::SSP_FRAGSET, 64'h0102, 32'h1, 0, 0);
    c.byte_order_flag = 1'b1;
    c.bitmap[0] = 32'h8000_0000;
    send(c, 1'b0);
    take(32'h0201_0000); take(32'h0100_0000); take(32'h0000_0080);
    left(0);
    $display("test fragset done");
  endtask
  // Limits: base zero, count zero, count 257, count 256
  task automatic test_limits();
    send(mk(ssp_pkg::SSP_SEQSET, 64'h0, 32'h1, 0, 0), 1'b1);
    send(mk(ssp_pkg::SSP_FRAGSET, 64'h1_0000_0000, 32'h1, 0, 0), 1'b1);
    send(mk(ssp_pkg::SSP_SEQSET, 64'h1, 32'h0, 0, 0), 1'b1);
    send(mk(ssp_pkg::SSP_SEQSET, 64'h1, 32'h101, 0, 0), 1'b1);
    send(mk(ssp_pkg::SSP_SEQSET, 64'h1, 32'h100, 0, 0), 1'b0);
    left(11);
    $display("test limits done");
  endtask
  // Parameter list with repeated id, pad and end record
  task automatic test_list();
    send(mk(ssp_pkg::SSP_SENT, 0, 0, 0, 0), 1'b1);
    send(mk(ssp_pkg::SSP_PARAM, 0, 0, 16'h0050, 16'h8), 1'b0);
    check("list_open", {31'h0, list_open}, 32'h1);
    c = mk(ssp_pkg::SSP_DATA, 0, 0, 0, 0);
    c.value = 32'h1122_3344;
    send(c, 1'b0);
    send(mk(ssp_pkg::SSP_PARAM, 0, 0, 16'h0050, 16'h4), 1'b1);
    send(c, 1'b0); send(c, 1'b1);
    send(mk(ssp_pkg::SSP_PARAM, 0, 0, 16'h0050, 16'h6), 1'b1);
    send(mk(ssp_pkg::SSP_PARAM, 0, 0, 16'h0050, 16'h4), 1'b0);
    send(c, 1'b0);
    send(mk(ssp_pkg::SSP_PAD, 0, 0, 0, 16'h4), 1'b0);
    send(mk(ssp_pkg::SSP_SENT, 0, 0, 0, 0), 1'b0);
    take(32'h0050_0008); take(32'h1122_3344); take(32'h1122_3344);
    take(32'h0050_0004); take(32'h1122_3344);
    take(32'h0000_0004); take(32'h0); take(32'h0001_0000);
    check("list_open", {31'h0, list_open}, 32'h0);
    left(0);
    $display("test list done");
  endtask
  // Compact endpoint in both byte orders and aligned payload fields
  task automatic test_endpoint_payload();
    c = mk(ssp_pkg::SSP_LOC, 64'hc0a8_0001_0000_1cf0, 0, 0, 0);
    send(c, 1'b0);
    take(32'hc0a8_0001); take(32'h0000_1cf0);
    c.byte_order_flag = 1'b1;
    send(c, 1'b0);
    take(32'h0100_a8c0); take(32'hf01c_0000);
    c = mk(ssp_pkg::SSP_PLD, 0, 0, 0, 0);
    c.value = 32'h0000_00ab;
    send(c, 1'b0);
    c.value = 32'h5566_7788;
    c.field_size = 2'h2;
    send(c, 1'b0);
    send(mk(ssp_pkg::SSP_PLEND, 0, 0, 0, 0), 1'b0);
    take(32'hab00_0000); take(32'h5566_7788);
    left(0);
    $display("test endpoint payload done");
  endtask
  initial begin
    arst_n = 1'b0; cmd_valid = 1'b0; cmd = '0; stall = 1'b1;
    n_fail = 0; checks_done = 0; cyc = 0;
    repeat (12) @(posedge core_clk);
    #1 arst_n = 1'b1;
    @(posedge core_clk); #1;
    test_seqset();
    test_fragset();
    test_limits();
    test_list();
    test_endpoint_payload();
    wrap_up();
  end
endmodule
